//--- hdl/sps_consts.svh
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH

// ----------------------------------------
// Control register bit positions
// ----------------------------------------
`define SPS_CR_IRQ_EN   7
`define SPS_CR_SPE      6
`define SPS_CR_MASTER_SELECT     4
`define SPS_CR_CLOCK_POLARITY     3
`define SPS_CR_CLOCK_PHASE     2

// ----------------------------------------
// Control/status register bit positions
// ----------------------------------------
`define SPS_CSR_DONE    7
`define SPS_CSR_WRITE_COLLISION_FLAG    6
`define SPS_CSR_OVR     5
`define SPS_CSR_MODE_FAULT_FLAG    4
`define SPS_CSR_SOD     2
`define SPS_CSR_SSM     1
`define SPS_CSR_SSI     0

// ----------------------------------------
// Sizes, reset values and timing
// ----------------------------------------
`define SPS_BYTE_W      8
`define SPS_SYNC_N      3
`define SPS_MDIV_W      8
`define SPS_MDIV_HALF   8'h02
`define SPS_EDGE_LAST   4'hF
`define SPS_BYTE_ZERO   8'h00
`define SPS_SYNC_HIGH   3'h7
`define SPS_SYNC_ZERO   3'h0
`define SPS_BIT_LAST    3'h7

`endif

//--- hdl/sps_pkg.sv
`include "sps_consts.svh"

package sps_pkg;

  // ----------------------------------------
  // CPU access strobes, one-cycle pulses
  // ----------------------------------------
  typedef struct packed {
    logic                   csr_rd;
    logic                   csr_wr;
    logic                   cr_wr;
    logic                   dr_rd;
    logic                   dr_wr;
    logic [`SPS_BYTE_W-1:0] wdata;
  } sps_cpu_req_t;

  // ----------------------------------------
  // CPU clock domain state
  // ----------------------------------------
  typedef struct packed {
    logic                   irq_en;
    logic                   spi_enable;
    logic                   master_select;
    logic                   clock_polarity;
    logic                   clock_phase;
    logic                   done;
    logic                   write_collision_flag;
    logic                   overrun_flag;
    logic                   mode_fault_flag;
    logic                   sod;
    logic                   soft_select_manage;
    logic                   soft_select_level;
    logic                   csr_seen;
    logic                   mode_fault_flag_seen;
    logic                   write_collision_flag_seen;
    logic [`SPS_BYTE_W-1:0] rx_buf;
    logic [`SPS_BYTE_W-1:0] tx;
    logic [`SPS_SYNC_N-1:0] ss_s;
    logic [`SPS_SYNC_N-1:0] tgl_s;
    logic [`SPS_SYNC_N-1:0] bsy_s;
    logic [`SPS_SYNC_N-1:0] miso_s;
    logic                   ss_acc;
    logic                   tgl_acc;
    logic                   bsy_acc;
    logic                   mrun;
    logic [`SPS_MDIV_W-1:0] mdiv;
    logic [3:0]             medge;
    logic [`SPS_BYTE_W-1:0] msh;
    logic                   mbit;
    logic                   sck_lvl;
    logic                   sck_oe_n;
    logic                   mosi_oe_n;
    logic                   miso_oe_n;
    logic                   irq;
    logic                   wake;
  } sps_state_t;

  // ----------------------------------------
  // Link clock domain state
  // ----------------------------------------
  typedef struct packed {
    logic [2:0]             cnt;
    logic [`SPS_BYTE_W-1:0] sh;
  } sps_shift_t;

  typedef struct packed {
    logic [`SPS_BYTE_W-1:0] rx;
    logic                   tgl;
  } sps_rxhold_t;

endpackage

//--- hdl/sps_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "sps_consts.svh"

module sps_core #(
  parameter logic [`SPS_MDIV_W-1:0] MDIV_HALF = `SPS_MDIV_HALF
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   nrst,
  // CPU side
  input  wire sps_pkg::sps_cpu_req_t  cpu_req,
  input  wire logic                   cpu_irq_mask,
  input  wire logic                   halt_mode,
  output logic [`SPS_BYTE_W-1:0]      cr_rdata,
  output logic [`SPS_BYTE_W-1:0]      csr_rdata,
  output logic [`SPS_BYTE_W-1:0]      dr_rdata,
  output logic                        spi_irq,
  output logic                        cpu_wake,
  // Serial clock pin
  input  wire logic                   sck_i,
  output logic                        sck_o,
  output logic                        sck_oe_n,
  // Master out / slave in pin
  input  wire logic                   mosi_i,
  output logic                        mosi_o,
  output logic                        mosi_oe_n,
  // Master in / slave out pin
  input  wire logic                   miso_i,
  output logic                        miso_o,
  output logic                        miso_oe_n,
  // Slave select pin, active low
  input  wire logic                   ss_n_i
);
  import sps_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // A synchronised level is taken only once stages two and three agree
  function automatic logic agree(input logic [`SPS_SYNC_N-1:0] s, input logic acc);
    agree = (s[1] == s[2]) ? s[2] : acc;
  endfunction

  sps_state_t  s_q, s_d;
  sps_shift_t  l_q, l_d;
  sps_rxhold_t h_q, h_d;
  logic        miso_neg_q;

  logic                   ss_raw_n;
  logic                   slave_rst_n;
  logic                   link_clk;
  logic                   ss_now;
  logic                   tgl_now;
  logic                   bsy_now;
  logic                   busy;
  logic                   byte_evt;
  logic [`SPS_BYTE_W-1:0] byte_val;
  logic                   m_tick;
  logic                   m_samp;
  logic                   m_shft;
  logic                   m_last;
  logic                   dr_take;
  logic                   cr_take;

  // ----------------------------------------
  // Link domain
  // ----------------------------------------
  // Soft select replaces the pin; level used raw only as the link reset
  assign ss_raw_n    = s_q.soft_select_manage ? s_q.soft_select_level : ss_n_i;
  // Shifter held in reset unless enabled slave and selected
  assign slave_rst_n = nrst & s_q.spi_enable & ~s_q.master_select & ~ss_raw_n;
  // Capture edge is the rising edge of this clock for all four modes
  assign link_clk    = sck_i ^ s_q.clock_polarity ^ s_q.clock_phase;

  always_comb begin
    l_d = l_q;
    h_d = h_q;
    // First edge takes the preloaded byte; tx is stable by the collision guard
    if (l_q.cnt == 3'h0) begin
      l_d.sh = {s_q.tx[`SPS_BYTE_W-2:0], mosi_i};
    end else begin
      l_d.sh = {l_q.sh[`SPS_BYTE_W-2:0], mosi_i};
    end
    l_d.cnt = l_q.cnt + 3'h1;
    if (l_q.cnt == `SPS_BIT_LAST) begin
      h_d.rx  = l_d.sh;
      h_d.tgl = ~h_q.tgl;
    end
  end

  always_ff @(posedge link_clk or negedge slave_rst_n) begin
    if (!slave_rst_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // Received byte and its toggle survive select going high between bytes
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      h_q <= '0;
    end else begin
      h_q <= h_d;
    end
  end

  // MISO changes on the launch edge so the master samples a settled bit
  always_ff @(negedge link_clk or negedge slave_rst_n) begin
    if (!slave_rst_n) begin
      miso_neg_q <= 1'b0;
    end else begin
      miso_neg_q <= l_q.sh[`SPS_BYTE_W-1];
    end
  end

  // Before the first edge the MSB of the loaded byte must already be out
  assign miso_o = (l_q.cnt == 3'h0) ? s_q.tx[`SPS_BYTE_W-1] : miso_neg_q;

  // ----------------------------------------
  // CPU domain
  // ----------------------------------------
  assign ss_now  = agree(s_q.ss_s, s_q.ss_acc);
  assign tgl_now = agree(s_q.tgl_s, s_q.tgl_acc);
  assign bsy_now = agree(s_q.bsy_s, s_q.bsy_acc);

  // With phase 0 a selected slave counts as busy; with phase 1 only mid-byte
  assign busy = s_q.master_select ? s_q.mrun : (s_q.clock_phase ? s_q.bsy_acc : ~s_q.ss_acc);

  assign m_tick = s_q.mrun && (s_q.mdiv == MDIV_HALF - 8'h01);
  assign m_samp = m_tick && (s_q.medge[0] == s_q.clock_phase);
  assign m_shft = m_tick && (s_q.medge[0] != s_q.clock_phase) && (s_q.medge != 4'h0);
  assign m_last = m_tick && (s_q.medge == `SPS_EDGE_LAST);

  assign byte_evt = m_last || (tgl_now != s_q.tgl_acc);
  assign byte_val = m_last ? {s_q.msh[`SPS_BYTE_W-2:0], (s_q.clock_phase ? s_q.miso_s[2] : s_q.mbit)} : h_q.rx;

  // CPU accesses are frozen in halt
  assign dr_take = cpu_req.dr_wr && !halt_mode;
  assign cr_take = cpu_req.cr_wr && !halt_mode;

  always_comb begin
    s_d = s_q;
    s_d.ss_s    = {s_q.ss_s[1:0], ss_n_i};
    s_d.tgl_s   = {s_q.tgl_s[1:0], h_q.tgl};
    s_d.bsy_s   = {s_q.bsy_s[1:0], (l_q.cnt != 3'h0)};
    s_d.miso_s  = {s_q.miso_s[1:0], miso_i};
    s_d.ss_acc  = s_q.soft_select_manage ? s_q.soft_select_level : ss_now;
    s_d.tgl_acc = tgl_now;
    s_d.bsy_acc = bsy_now;

    // Software accesses, ordered so the sequences see the old flags
    if (!halt_mode) begin
      if (cpu_req.csr_rd || cpu_req.csr_wr) begin
        if (s_q.done) begin
          s_d.csr_seen = 1'b1;
        end
        if (s_q.write_collision_flag) begin
          s_d.write_collision_flag_seen = 1'b1;
        end
      end
      if (cpu_req.csr_rd) begin
        s_d.overrun_flag = 1'b0;
        if (s_q.mode_fault_flag) begin
          s_d.mode_fault_flag_seen = 1'b1;
        end
      end
      if (cpu_req.csr_wr) begin
        s_d.sod = cpu_req.wdata[`SPS_CSR_SOD];
        s_d.soft_select_manage = cpu_req.wdata[`SPS_CSR_SSM];
        s_d.soft_select_level = cpu_req.wdata[`SPS_CSR_SSI];
      end
      if (cr_take) begin
        s_d.irq_en = cpu_req.wdata[`SPS_CR_IRQ_EN];
        s_d.clock_polarity   = cpu_req.wdata[`SPS_CR_CLOCK_POLARITY];
        s_d.clock_phase   = cpu_req.wdata[`SPS_CR_CLOCK_PHASE];
        // Enable and master refused while a fault stands unacknowledged
        s_d.spi_enable  = cpu_req.wdata[`SPS_CR_SPE] & (~s_q.mode_fault_flag | s_q.mode_fault_flag_seen);
        s_d.master_select = cpu_req.wdata[`SPS_CR_MASTER_SELECT] & (~s_q.mode_fault_flag | s_q.mode_fault_flag_seen);
        if (s_q.mode_fault_flag_seen) begin
          s_d.mode_fault_flag      = 1'b0;
          s_d.mode_fault_flag_seen = 1'b0;
        end
      end
      if ((cpu_req.dr_rd || cpu_req.dr_wr) && s_q.csr_seen) begin
        s_d.done     = 1'b0;
        s_d.csr_seen = 1'b0;
      end
      if ((cpu_req.dr_rd || cpu_req.dr_wr) && s_q.write_collision_flag_seen) begin
        s_d.write_collision_flag      = 1'b0;
        s_d.write_collision_flag_seen = 1'b0;
      end
      // Writes inhibited while done stands and status not yet read
      if (dr_take && !(s_q.done && !s_q.csr_seen)) begin
        if (busy) begin
          s_d.write_collision_flag = 1'b1;
        end else begin
          s_d.tx = cpu_req.wdata;
          if (s_q.master_select && s_q.spi_enable) begin
            s_d.mrun  = 1'b1;
            s_d.mdiv  = '0;
            s_d.medge = 4'h0;
            s_d.msh   = cpu_req.wdata;
          end
        end
      end
    end

    // Master engine, stopped in halt
    if (s_q.mrun && !halt_mode) begin
      s_d.mdiv = m_tick ? '0 : s_q.mdiv + 8'h01;
      if (m_tick) begin
        s_d.sck_lvl = ~s_q.sck_lvl;
        s_d.medge   = s_q.medge + 4'h1;
      end
      if (m_samp) begin
        s_d.mbit = s_q.miso_s[2];
      end
      if (m_shft) begin
        s_d.msh = {s_q.msh[`SPS_BYTE_W-2:0], s_q.mbit};
      end
      if (m_last) begin
        s_d.mrun = 1'b0;
      end
    end
    if (!s_d.mrun) begin
      s_d.sck_lvl = s_d.clock_polarity;
    end

    // Byte completion; flags set here win over clears above
    if (byte_evt) begin
      if (s_q.done) begin
        s_d.overrun_flag = 1'b1;
      end else begin
        s_d.rx_buf = byte_val;
      end
      s_d.done     = 1'b1;
      s_d.csr_seen = 1'b0;
    end

    // Mode fault only as enabled master
    if (s_q.master_select && s_q.spi_enable && !ss_now && !s_q.soft_select_manage) begin
      s_d.mode_fault_flag      = 1'b1;
      s_d.mode_fault_flag_seen = 1'b0;
      s_d.spi_enable       = 1'b0;
      s_d.master_select      = 1'b0;
      s_d.mrun      = 1'b0;
      s_d.sck_lvl   = s_q.clock_polarity;
    end
    if (s_q.master_select && s_q.spi_enable && s_q.soft_select_manage && !s_q.soft_select_level) begin
      s_d.mode_fault_flag      = 1'b1;
      s_d.mode_fault_flag_seen = 1'b0;
      s_d.spi_enable       = 1'b0;
      s_d.master_select      = 1'b0;
      s_d.mrun      = 1'b0;
      s_d.sck_lvl   = s_q.clock_polarity;
    end

    // Pin enables, low while driving
    s_d.sck_oe_n  = ~(s_d.spi_enable & s_d.master_select);
    s_d.mosi_oe_n = ~(s_d.spi_enable & s_d.master_select & ~s_d.sod);
    s_d.miso_oe_n = ~(s_d.spi_enable & ~s_d.master_select & ~s_d.sod & ~s_d.ss_acc);

    // Interrupt and wake; halt exits only on a finished byte
    s_d.irq  = s_d.irq_en & ~cpu_irq_mask & (s_d.done | s_d.overrun_flag | s_d.mode_fault_flag);
    s_d.wake = halt_mode ? (s_d.irq_en & s_d.done) : (s_d.irq_en & (s_d.done | s_d.overrun_flag | s_d.mode_fault_flag));
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q           <= '0;
      s_q.ss_s      <= `SPS_SYNC_HIGH;
      s_q.ss_acc    <= 1'b1;
      s_q.sck_oe_n  <= 1'b1;
      s_q.mosi_oe_n <= 1'b1;
      s_q.miso_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cr_rdata  = {s_q.irq_en, s_q.spi_enable, 1'b0, s_q.master_select, s_q.clock_polarity, s_q.clock_phase, 2'b00};
  assign csr_rdata = {s_q.done, s_q.write_collision_flag, s_q.overrun_flag, s_q.mode_fault_flag, 1'b0, s_q.sod, s_q.soft_select_manage, s_q.soft_select_level};
  assign dr_rdata  = s_q.rx_buf;
  assign spi_irq   = s_q.irq;
  assign cpu_wake  = s_q.wake;
  assign sck_o     = s_q.sck_lvl;
  assign sck_oe_n  = s_q.sck_oe_n;
  assign mosi_o    = s_q.msh[`SPS_BYTE_W-1];
  assign mosi_oe_n = s_q.mosi_oe_n;
  assign miso_oe_n = s_q.miso_oe_n;

endmodule

`default_nettype wire

//--- tb/sps_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sps_chk (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  nrst,
  // CPU side
  input wire sps_pkg::sps_cpu_req_t cpu_req,
  input wire logic                  halt_mode,
  input wire logic [7:0]            cr_rdata,
  input wire logic [7:0]            csr_rdata,
  input wire logic                  spi_irq,
  // Pin enables
  input wire logic                  sck_oe_n,
  input wire logic                  miso_oe_n
);
  import sps_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_fault_set;
    $rose(csr_rdata[4]);
  endsequence
  property p_fault_drop;
    s_fault_set |-> ##[0:1] (!cr_rdata[6] && !cr_rdata[4]);
  endproperty
  property p_fault_master;
    s_fault_set |-> $past(cr_rdata[4]);
  endproperty
  property p_fault_clear;
    $fell(csr_rdata[4]) |-> $past(cpu_req.cr_wr);
  endproperty
  property p_ovr_clear;
    $fell(csr_rdata[5]) |-> $past(cpu_req.csr_rd);
  endproperty
  property p_done_clear;
    $fell(csr_rdata[7]) |-> $past(cpu_req.dr_rd || cpu_req.dr_wr);
  endproperty
  property p_write_collision_flag_set;
    $rose(csr_rdata[6]) |-> $past(cpu_req.dr_wr);
  endproperty
  // Collision alone never interrupts
  property p_no_irq;
    (!csr_rdata[7] && !csr_rdata[5] && !csr_rdata[4]) [*2] |-> !spi_irq;
  endproperty
  property p_irq_en;
    spi_irq |-> cr_rdata[7] || $past(cr_rdata[7]);
  endproperty
  property p_halt_frozen;
    halt_mode && $past(halt_mode) |-> $stable(cr_rdata);
  endproperty
  property p_master_pins;
    !sck_oe_n |-> (cr_rdata[6] && cr_rdata[4]) || $past(cr_rdata[6] && cr_rdata[4]);
  endproperty
  property p_slave_pins;
    !miso_oe_n |-> (cr_rdata[6] && !cr_rdata[4]) || $past(cr_rdata[6] && !cr_rdata[4]);
  endproperty
  a_fault_drop: assert property (p_fault_drop) else $error("fault kept enable");
  a_fault_master: assert property (p_fault_master) else $error("fault as slave");
  a_fault_clear: assert property (p_fault_clear) else $error("fault cleared early");
  a_ovr_clear: assert property (p_ovr_clear) else $error("overrun cleared early");
  a_done_clear: assert property (p_done_clear) else $error("done cleared early");
  a_write_collision_flag_set: assert property (p_write_collision_flag_set) else $error("collision without write");
  a_no_irq: assert property (p_no_irq) else $error("irq without event");
  a_irq_en: assert property (p_irq_en) else $error("irq while disabled");
  a_halt_frozen: assert property (p_halt_frozen) else $error("control moved in halt");
  a_master_pins: assert property (p_master_pins) else $error("clock driven as slave");
  a_slave_pins: assert property (p_slave_pins) else $error("slave out while off");
endmodule
`default_nettype wire

//--- tb/sps_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module sps_master_model (
  // Pins driven by the master
  output var logic sck,
  output var logic mosi,
  output var logic ss_n,
  // Slave output pin
  input  wire logic miso,
  input  wire logic miso_oe_n
);
  logic clock_polarity;
  logic clock_phase;
  initial begin
    clock_polarity = 1'b0;
    clock_phase = 1'b0;
    sck  = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
  end
  task automatic set_mode(input logic p, input logic h);
    clock_polarity = p;
    clock_phase = h;
    sck  = p;
  endtask
  // Edges offset by 7 ns so the link clock is not in step with clk
  task automatic xfer(input logic [7:0] tx, input logic keep_sel, output logic [7:0] rx);
    ss_n = 1'b0;
    #207;
    for (int i = 7; i >= 0; i--) begin
      if (!clock_phase) mosi = tx[i];
      #40;
      sck = ~clock_polarity;
      if (clock_phase) mosi = tx[i];
      else rx[i] = miso_oe_n ? 1'hX : miso;
      #40;
      sck = clock_polarity;
      if (clock_phase) rx[i] = miso_oe_n ? 1'hX : miso;
    end
    #193;
    mosi = ~mosi;
    ss_n = ~(keep_sel & clock_phase);
    #200;
  endtask
endmodule
`default_nettype wire

//--- tb/sps_core_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    n_compared++; \
    if ((got) !== (ex)) begin \
      err_total++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
    end \
  end
module sps_core_test;
  import sps_pkg::*;
  localparam logic [4:0] CSR_RD = 5'h10;
  localparam logic [4:0] CSR_WR = 5'h08;
  localparam logic [4:0] CR_WR  = 5'h04;
  localparam logic [4:0] DR_RD  = 5'h02;
  localparam logic [4:0] DR_WR  = 5'h01;
  logic         clk, nrst, cpu_irq_mask, halt_mode, miso_i, spi_irq, cpu_wake;
  logic         sck, mosi, ss_n, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
  logic [7:0]   cr_rdata, csr_rdata, dr_rdata, rx;
  sps_cpu_req_t req;
  int           err_total, n_compared;
  sps_core i_sps_core (.clk(clk), .nrst(nrst), .cpu_req(req), .cpu_irq_mask(cpu_irq_mask),
    .halt_mode(halt_mode), .cr_rdata(cr_rdata), .csr_rdata(csr_rdata), .dr_rdata(dr_rdata),
    .spi_irq(spi_irq), .cpu_wake(cpu_wake), .sck_i(sck), .sck_o(sck_o), .sck_oe_n(sck_oe_n),
    .mosi_i(mosi), .mosi_o(mosi_o), .mosi_oe_n(mosi_oe_n), .miso_i(miso_i), .miso_o(miso_o),
    .miso_oe_n(miso_oe_n), .ss_n_i(ss_n));
  sps_master_model i_sps_master_model (.sck(sck), .mosi(mosi), .ss_n(ss_n), .miso(miso_o),
    .miso_oe_n(miso_oe_n));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic acc(input logic [4:0] sel, input logic [7:0] d);
    @(negedge clk);
    req = {sel, d};
    @(negedge clk);
    req = '0;
    @(negedge clk);
  endtask
  task automatic wait_done;
    int k;
    k = 0;
    while (csr_rdata[7] !== 1'b1 && k < 300) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    `CHK("done", 1'b1, csr_rdata[7])
  endtask
  task automatic stop_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    stop_test();
  end
  initial begin
    nrst = 1'b0;
    req = '0;
    cpu_irq_mask = 1'b0;
    halt_mode = 1'b0;
    miso_i = 1'b1;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    `CHK("regs", 24'h000000, {cr_rdata, csr_rdata, dr_rdata})
    `CHK("oe", 3'h7, {sck_oe_n, mosi_oe_n, miso_oe_n})
    // Every polarity and phase, irq masked in the last
    for (int m = 0; m < 4; m++) begin
      acc(CR_WR, 8'h00);
      i_sps_master_model.set_mode(m[1], m[0]);
      cpu_irq_mask = (m == 3);
      acc(CR_WR, {4'hC, m[1], m[0], 2'h0});
      acc(DR_WR, 8'hA5 ^ m[7:0]);
      i_sps_master_model.xfer(8'h3C + m[7:0], 1'b0, rx);
      `CHK("miso", 8'hA5 ^ m[7:0], rx)
      wait_done();
      `CHK("rx buf", 8'h3C + m[7:0], dr_rdata)
      `CHK("irq", m != 3, spi_irq)
      acc(DR_WR, 8'h11);
      acc(CSR_RD, 8'h00);
      acc(DR_RD, 8'h00);
      `CHK("done clr", 2'h0, {csr_rdata[7], spi_irq})
    end
    // Two bytes in halt: first kept, overrun
    cpu_irq_mask = 1'b0;
    halt_mode = 1'b1;
    i_sps_master_model.xfer(8'h5A, 1'b1, rx);
    `CHK("echo", 8'hA6, rx)
    wait_done();
    `CHK("wake", 1'b1, cpu_wake)
    i_sps_master_model.xfer(8'hC3, 1'b0, rx);
    @(negedge clk);
    halt_mode = 1'b0;
    repeat (8) @(negedge clk);
    `CHK("ovr", 1'b1, csr_rdata[5])
    `CHK("first", 8'h5A, dr_rdata)
    acc(CSR_RD, 8'h00);
    `CHK("ovr clr", 1'b0, csr_rdata[5])
    acc(DR_RD, 8'h00);
    // Write in mid-byte is dropped
    acc(CR_WR, 8'h00);
    i_sps_master_model.set_mode(1'b0, 1'b0);
    acc(CR_WR, 8'h40);
    acc(DR_WR, 8'h96);
    fork
      i_sps_master_model.xfer(8'h69, 1'b0, rx);
      begin
        #400;
        acc(DR_WR, 8'hFF);
      end
    join
    `CHK("kept tx", 8'h96, rx)
    wait_done();
    `CHK("write_collision_flag", 2'h2, {csr_rdata[6], spi_irq})
    acc(CSR_RD, 8'h00);
    acc(DR_RD, 8'h00);
    `CHK("write_collision_flag clr", 2'h0, csr_rdata[7:6])
    // Mode fault through soft select
    acc(CSR_WR, 8'h03);
    acc(CR_WR, 8'hD0);
    repeat (4) @(negedge clk);
    `CHK("master", 1'b0, sck_oe_n)
    acc(CSR_WR, 8'h02);
    repeat (4) @(negedge clk);
    `CHK("mode_fault_flag", 2'h3, {csr_rdata[4], spi_irq})
    `CHK("forced", 2'h0, {cr_rdata[6], cr_rdata[4]})
    acc(CSR_WR, 8'h03);
    acc(CR_WR, 8'h50);
    `CHK("refused", 2'h0, {cr_rdata[6], cr_rdata[4]})
    acc(CSR_RD, 8'h00);
    acc(CR_WR, 8'h50);
    `CHK("mode_fault_flag clr", 3'h3, {csr_rdata[4], cr_rdata[6], cr_rdata[4]})
    // Master byte with MISO held high
    acc(DR_WR, 8'hB4);
    wait_done();
    `CHK("master rx", 8'hFF, dr_rdata)
    `CHK("sck idle", 2'h0, {sck_o, sck_oe_n})
    stop_test();
  end
endmodule
bind sps_core sps_chk i_sps_chk (.clk(clk), .nrst(nrst), .cpu_req(cpu_req), .halt_mode(halt_mode),
  .cr_rdata(cr_rdata), .csr_rdata(csr_rdata), .spi_irq(spi_irq), .sck_oe_n(sck_oe_n),
  .miso_oe_n(miso_oe_n));
`default_nettype wire
